// file: owdh_host.v
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`include "owdh_defs.vh"
// Host controller for a one-wire half-duplex debug port
module owdh_host #(
    parameter BREAK_CYC = `OWDH_BREAK_CYC
) (
    input  wire        i_ref_clk,  // 40 MHz clock
    input  wire        i_srst,     // Sync reset, high
    input  wire [3:0]  i_awaddr,   // AXI write address
    input  wire        i_awvalid,  // AXI aw valid
    output reg         o_awready,  // AXI aw ready
    input  wire [31:0] i_wdata,    // AXI write data
    input  wire [3:0]  i_wstrb,    // AXI byte strobes
    input  wire        i_wvalid,   // AXI w valid
    output reg         o_wready,   // AXI w ready
    output reg  [1:0]  o_bresp,    // AXI write resp
    output reg         o_bvalid,   // AXI b valid
    input  wire        i_bready,   // AXI b ready
    input  wire [3:0]  i_araddr,   // AXI read address
    input  wire        i_arvalid,  // AXI ar valid
    output reg         o_arready,  // AXI ar ready
    output reg  [31:0] o_rdata,    // AXI read data
    output reg  [1:0]  o_rresp,    // AXI read resp
    output reg         o_rvalid,   // AXI r valid
    input  wire        i_rready,   // AXI r ready
    input  wire        i_wire_in,  // Debug wire level
    output reg         o_wire_out, // Debug wire drive value
    output reg         o_wire_oe_n // Low while driving
);
    localparam S_IDLE = 3'd0, S_BRK = 3'd1, S_ENLOW = 3'd2, S_ENWAIT = 3'd3;
    localparam S_TX = 3'd4, S_RXWAIT = 3'd5, S_RX = 3'd6, S_GAP = 3'd7;

    reg  [2:0]  state_reg;
    reg  [31:0] cnt_reg;
    reg  [15:0] div_reg;
    reg         parity_check_disable_reg;
    reg  [11:0] sh_reg;
    reg  [3:0]  bit_reg;
    reg  [7:0]  txd_reg;
    reg         busy_reg, err_reg, done_reg, ovf_reg;
    reg  [3:0]  wp_reg, rp_reg;
    reg  [2:0]  cmd_reg;
    reg         sync1_reg, sync2_reg;
    reg         aw_ok_reg, w_ok_reg;
    reg  [3:0]  aw_reg;
    reg  [31:0] wd_reg;
    reg         ram_we;
    reg  [8:0]  ram_wd;
    wire [8:0]  ram_rd;
    wire [15:0] half_div = {1'b0, div_reg[15:1]};

    // Even parity over a data byte
    function par8;
        input [7:0] d;
        begin
            par8 = ^d;
        end
    endfunction

    // Builds the 12-bit frame, LSB sent first
    // frame layout
    function [11:0] frame;
        input [7:0] d;
        begin
            frame = {2'b11, par8(d), d, 1'b0};
        end
    endfunction

    owdh_reg_ram #(.AW(4), .DW(9)) u_ram (
        .i_ref_clk (i_ref_clk),
        .i_we      (ram_we),
        .i_waddr   (wp_reg),
        .i_wdata   (ram_wd),
        .i_raddr   (rp_reg),
        .o_rdata   (ram_rd)
    );

    // Two-flop synchroniser on the pin
    always @(posedge i_ref_clk) begin
        if (i_srst) begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
        end else begin
            sync1_reg <= i_wire_in;
            sync2_reg <= sync1_reg;
        end
    end

    // AXI write side: address and data taken in either order
    always @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_awready <= 1'b1;
            o_wready  <= 1'b1;
            o_bvalid  <= 1'b0;
            o_bresp   <= 2'b00;
            aw_ok_reg <= 1'b0;
            w_ok_reg  <= 1'b0;
            aw_reg    <= 4'h0;
            wd_reg    <= 32'h0;
            cmd_reg   <= `OWDH_CMD_NONE;
            parity_check_disable_reg  <= 1'b0;
            txd_reg   <= 8'h00;
            div_reg   <= `OWDH_DIV_RST;
        end else begin
            cmd_reg <= `OWDH_CMD_NONE;
            if (o_awready && i_awvalid) begin
                aw_reg    <= i_awaddr;
                aw_ok_reg <= 1'b1;
                o_awready <= 1'b0;
            end
            if (o_wready && i_wvalid) begin
                wd_reg   <= i_wdata;
                w_ok_reg <= 1'b1;
                o_wready <= 1'b0;
            end
            if (aw_ok_reg && w_ok_reg && !o_bvalid) begin
                o_bvalid  <= 1'b1;
                o_bresp   <= 2'b00;
                aw_ok_reg <= 1'b0;
                w_ok_reg  <= 1'b0;
                case (aw_reg)
                    `OWDH_REG_CTRL: begin
                        if (i_wstrb[0]) begin
                            cmd_reg  <= wd_reg[2:0];
                            parity_check_disable_reg <= wd_reg[`OWDH_CTRL_PARITY_CHECK_DISABLE_BIT];
                        end
                        if (i_wstrb[2] && wd_reg[31:16] != 16'h0) begin
                            div_reg <= wd_reg[31:16];
                        end
                    end
                    `OWDH_REG_TXDATA: begin
                        txd_reg <= wd_reg[7:0];
                    end
                    `OWDH_REG_STATUS, `OWDH_REG_RXDATA: begin
                        o_bresp <= 2'b00;
                    end
                    default: begin
                        o_bresp <= 2'b10;
                    end
                endcase
            end
            if (o_bvalid && i_bready) begin
                o_bvalid  <= 1'b0;
                o_awready <= 1'b1;
                o_wready  <= 1'b1;
            end
        end
    end

    // AXI read side; pops the receive memory on a data read
    always @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_arready <= 1'b1;
            o_rvalid  <= 1'b0;
            o_rdata   <= 32'h0;
            o_rresp   <= 2'b00;
            rp_reg    <= 4'h0;
        end else if (o_arready && i_arvalid) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b1;
            o_rresp   <= 2'b00;
            case (i_araddr)
                `OWDH_REG_CTRL: o_rdata <= {div_reg, 11'h0, parity_check_disable_reg, 4'h0};
                `OWDH_REG_STATUS: o_rdata <= {24'h0, ovf_reg, wp_reg != rp_reg,
                    done_reg, err_reg, 3'h0, busy_reg};
                `OWDH_REG_RXDATA: begin
                    o_rdata <= {23'h0, ram_rd};
                    if (wp_reg != rp_reg) begin
                        rp_reg <= rp_reg + 4'h1;
                    end
                end
                `OWDH_REG_TXDATA: o_rdata <= {24'h0, txd_reg};
                default: begin
                    o_rdata <= 32'h0;
                    o_rresp <= 2'b10;
                end
            endcase
        end else if (o_rvalid && i_rready) begin
            o_rvalid  <= 1'b0;
            o_arready <= 1'b1;
        end
    end

    // Wire engine: break, enable pulse, send frame, receive frame
    always @(posedge i_ref_clk) begin
        ram_we <= 1'b0;
        if (i_srst) begin
            state_reg   <= S_IDLE;
            cnt_reg     <= 32'h0;
            sh_reg      <= 12'hfff;
            bit_reg     <= 4'h0;
            busy_reg    <= 1'b0;
            err_reg     <= 1'b0;
            done_reg    <= 1'b0;
            ovf_reg     <= 1'b0;
            wp_reg      <= 4'h0;
            ram_wd      <= 9'h0;
            o_wire_out  <= 1'b1;
            o_wire_oe_n <= 1'b1;
        end else begin
            case (state_reg)
                S_IDLE: begin
                    o_wire_oe_n <= 1'b1;
                    o_wire_out  <= 1'b1;
                    busy_reg    <= 1'b0;
                    cnt_reg     <= 32'h0;
                    bit_reg     <= 4'h0;
                    case (cmd_reg)
                        `OWDH_CMD_SEND: begin
                            sh_reg    <= frame(txd_reg);
                            state_reg <= S_TX;
                            busy_reg  <= 1'b1;
                            done_reg  <= 1'b0;
                        end
                        `OWDH_CMD_RECV: begin
                            state_reg <= S_RXWAIT;
                            busy_reg  <= 1'b1;
                            done_reg  <= 1'b0;
                            err_reg   <= 1'b0;
                        end
                        `OWDH_CMD_BREAK: begin
                            state_reg <= S_BRK;
                            busy_reg  <= 1'b1;
                            done_reg  <= 1'b0;
                        end
                        `OWDH_CMD_ENABLE: begin
                            state_reg <= S_ENLOW;
                            busy_reg  <= 1'b1;
                            done_reg  <= 1'b0;
                        end
                        default: begin
                            state_reg <= S_IDLE;
                        end
                    endcase
                end
                S_BRK: begin
                    o_wire_oe_n <= 1'b0;
                    o_wire_out  <= 1'b0;
                    cnt_reg     <= cnt_reg + 32'h1;
                    if (cnt_reg == BREAK_CYC - 1) begin
                        o_wire_oe_n <= 1'b1;
                        o_wire_out  <= 1'b1;
                        cnt_reg     <= 32'h0;
                        state_reg   <= S_GAP;
                    end
                end
                S_ENLOW: begin
                    o_wire_oe_n <= 1'b0;
                    o_wire_out  <= 1'b0;
                    cnt_reg     <= cnt_reg + 32'h1;
                    if (cnt_reg == `OWDH_ENLOW_CYC - 1) begin
                        o_wire_oe_n <= 1'b1;
                        o_wire_out  <= 1'b1;
                        cnt_reg     <= 32'h0;
                        state_reg   <= S_ENWAIT;
                    end
                end
                S_ENWAIT: begin
                    // Wait for device to release the pin high
                    if (cnt_reg < 32'h4) begin
                        cnt_reg <= cnt_reg + 32'h1;
                    end else if (sync2_reg) begin
                        state_reg <= S_IDLE;
                        done_reg  <= 1'b1;
                    end
                end
                S_TX: begin
                    o_wire_oe_n <= 1'b0;
                    o_wire_out  <= sh_reg[0];
                    cnt_reg     <= cnt_reg + 32'h1;
                    if (cnt_reg[15:0] == div_reg - 16'h1) begin
                        cnt_reg <= 32'h0;
                        sh_reg  <= {1'b1, sh_reg[11:1]};
                        bit_reg <= bit_reg + 4'h1;
                        if (bit_reg == `OWDH_FRAME_BITS - 4'h1) begin
                            o_wire_oe_n <= 1'b1;
                            o_wire_out  <= 1'b1;
                            state_reg   <= S_IDLE;
                            done_reg    <= 1'b1;
                        end
                    end
                end
                S_RXWAIT: begin
                    // wait for device answer start bit
                    if (!sync2_reg) begin
                        state_reg <= S_RX;
                        cnt_reg   <= {16'h0, half_div};
                        bit_reg   <= 4'h0;
                    end
                end
                S_RX: begin
                    cnt_reg <= cnt_reg + 32'h1;
                    if (cnt_reg[15:0] == div_reg - 16'h1) begin
                        cnt_reg <= 32'h0;
                        sh_reg  <= {sync2_reg, sh_reg[11:1]};
                        bit_reg <= bit_reg + 4'h1;
                        if (bit_reg == `OWDH_FRAME_BITS - 4'h1) begin
                            state_reg <= S_IDLE;
                            done_reg  <= 1'b1;
                            ram_we    <= 1'b1;
                            ram_wd    <= {1'b0, sh_reg[9:2]};
                            if (!sync2_reg || !sh_reg[11] || sh_reg[1] ||
                                (!parity_check_disable_reg && (sh_reg[10] != par8(sh_reg[9:2])))) begin
                                err_reg   <= 1'b1;
                                ram_wd[8] <= 1'b1;
                            end
                            if (wp_reg + 4'h1 == rp_reg) begin
                                ovf_reg <= 1'b1;
                                // Drop the byte so the queue is not emptied
                                ram_we  <= 1'b0;
                            end
                        end
                    end
                end
                S_GAP: begin
                    cnt_reg <= cnt_reg + 32'h1;
                    if (cnt_reg[15:0] == div_reg - 16'h1) begin
                        cnt_reg <= 32'h0;
                        bit_reg <= bit_reg + 4'h1;
                        if (bit_reg == `OWDH_FRAME_BITS - 4'h1) begin
                            state_reg <= S_IDLE;
                            done_reg  <= 1'b1;
                        end
                    end
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
            if (ram_we) begin
                wp_reg <= wp_reg + 4'h1;
            end
        end
    end
endmodule // owdh_host

// file: owdh_defs.vh
`ifndef OWDH_DEFS_VH
`define OWDH_DEFS_VH
// Register byte offsets
`define OWDH_REG_CTRL       4'h0
`define OWDH_REG_STATUS     4'h4
`define OWDH_REG_TXDATA     4'h8
`define OWDH_REG_RXDATA     4'hc
// Control fields
`define OWDH_CTRL_CMD_LSB   0
`define OWDH_CTRL_PARITY_CHECK_DISABLE_BIT  4
`define OWDH_CTRL_DIV_LSB   16
// Commands
`define OWDH_CMD_NONE       3'h0
`define OWDH_CMD_SEND       3'h1
`define OWDH_CMD_RECV       3'h2
`define OWDH_CMD_BREAK      3'h3
`define OWDH_CMD_ENABLE     3'h4
// Frame constants
`define OWDH_SYNC_CHAR      8'h55
`define OWDH_FRAME_BITS     4'hc
`define OWDH_BREAK_BITS     8'h0c
// Timing in ns at 40 MHz
`define OWDH_CLK_NS         25
`define OWDH_BREAK_NS       24600000
`define OWDH_BREAK_CYC      (`OWDH_BREAK_NS / `OWDH_CLK_NS)
`define OWDH_ENLOW_NS       500
`define OWDH_ENLOW_CYC      ((`OWDH_ENLOW_NS + `OWDH_CLK_NS - 1) / `OWDH_CLK_NS)
`define OWDH_DIV_RST        16'h00b2
`endif

// file: owdh_reg_ram.v
// Small register-output memory for received bytes
module owdh_reg_ram #(
    parameter AW = 4,
    parameter DW = 9
) (
    input  wire          i_ref_clk, // Clock
    input  wire          i_we,      // Write enable
    input  wire [AW-1:0] i_waddr,   // Write address
    input  wire [DW-1:0] i_wdata,   // Write data
    input  wire [AW-1:0] i_raddr,   // Read address
    output reg  [DW-1:0] o_rdata    // Registered read data
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    // Write port and registered read port
    always @(posedge i_ref_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end
endmodule // owdh_reg_ram

// file: owdh_host_chk.sv
module owdh_host_chk (
    input wire logic        i_ref_clk,  // Clock
    input wire logic        i_srst,     // Reset
    input wire logic        i_awvalid,  // Aw valid
    input wire logic        o_awready,  // Aw ready
    input wire logic        i_wvalid,   // W valid
    input wire logic        o_wready,   // W ready
    input wire logic        o_bvalid,   // B valid
    input wire logic [1:0]  o_bresp,    // B resp
    input wire logic        i_bready,   // B ready
    input wire logic [3:0]  i_araddr,   // Ar address
    input wire logic        i_arvalid,  // Ar valid
    input wire logic        o_arready,  // Ar ready
    input wire logic [31:0] o_rdata,    // R data
    input wire logic [1:0]  o_rresp,    // R resp
    input wire logic        o_rvalid,   // R valid
    input wire logic        i_rready,   // R ready
    input wire logic        o_wire_out, // Wire value
    input wire logic        o_wire_oe_n // Low while driving
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);

    // Wire released and no answer pending once reset lifts
    chk_reset_quiet: assert property (
        $past(i_srst) |-> o_wire_oe_n && !o_bvalid && !o_rvalid)
        else $error("bus or wire busy after reset");
    // Every frame, break or pulse opens with a low stretch
    chk_start_low: assert property (
        $fell(o_wire_oe_n) |-> (!o_wire_oe_n && !o_wire_out) [*8])
        else $error("driven wire not low at frame start");
    // One answer per request
    chk_b_done: assert property (o_bvalid && i_bready |=> !o_bvalid)
        else $error("write answer repeated");
    chk_r_done: assert property (o_rvalid && i_rready |=> !o_rvalid)
        else $error("read answer repeated");
    chk_r_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
        else $error("read answer late");
    chk_r_unmap: assert property (
        i_arvalid && o_arready && i_araddr[1:0] != 2'h0 |=>
        o_rresp == 2'h2 && o_rdata == 32'h0)
        else $error("unmapped read not refused");
    // No new write accepted while one is pending
    chk_w_block: assert property (o_bvalid |-> !o_awready && !o_wready)
        else $error("write taken while pending");
    chk_b_answer: assert property (
        i_awvalid && o_awready && i_wvalid && o_wready |-> ##[1:3] o_bvalid)
        else $error("write answer missing");

    cover property ($fell(o_wire_oe_n));
    cover property (o_bvalid && o_bresp == 2'h2);
    cover property (o_rvalid && o_rresp == 2'h2);
endmodule // owdh_host_chk

// file: owdh_dev_model.sv
module owdh_dev_model #(
    parameter int GUARD = 8,  // Idle bits before a reply
    parameter int WAKE  = 40  // Clocks held low on wake-up
) (
    input  wire logic  i_clk,     // Bench clock
    input  wire logic  i_line,    // Resolved wire level
    input  wire logic  i_bad_par, // Corrupt reply parity
    output logic       o_out,     // Driven value
    output logic       o_oe_n,    // Low while driving
    output logic       o_stb,     // Rises per byte taken
    output logic [8:0] o_rx,      // Error flag and byte
    output int         o_bit,     // Measured bit in clocks
    output int         o_breaks   // Breaks seen
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam real CLK_NS = 25.0;
    localparam real PHY_NS = 250.0; // Default 4 MHz port clock
    logic        enabled, synced, stuck;
    logic [1:0]  clk_sel;
    logic [11:0] f;
    realtime     t0, t_rel;

    // Wait a number of measured bit times
    task automatic bits(input real n);
        repeat (int'(n * o_bit)) @(posedge i_clk);
    endtask

    // Wake-up, sync measure, frame receive, break and reply
    initial begin
        {o_out, o_oe_n, o_stb, enabled, synced, stuck} = 6'b110000;
        o_rx = 9'h0;
        o_bit = 0;
        o_breaks = 0;
        t_rel = 0;
        clk_sel = 2'h3;
        forever begin
            @(negedge i_line);
            t0 = $realtime;
            if (!enabled) begin
                @(posedge i_line);
                {o_out, o_oe_n} = 2'b00;
                repeat (WAKE) @(posedge i_clk);
                {o_out, o_oe_n} <= 2'b11;
                enabled = 1;
                t_rel = $realtime;
            end else if (o_bit == 0 && t0 - t_rel >= 65536 * PHY_NS) begin
                // sync start bit came after the wake time-out
                enabled = 0;
            end else if (!synced) begin
                @(posedge i_line);
                if (o_bit > 0 && $realtime - t0 >= 12 * o_bit * CLK_NS) begin
                    {stuck, clk_sel} = 3'b011;
                    o_breaks++;
                end else begin
                    repeat (4) @(negedge i_line);
                    o_bit = int'(($realtime - t0) / (8 * CLK_NS));
                    enabled = (o_bit * 8 <= 65535) && (o_bit > 1);
                    synced = enabled;
                end
            end else begin
                bits(0.5);
                for (int i = 0; i < 12; i++) begin
                    f[i] = i_line;
                    if (i < 11) bits(1);
                end
                if (f == 12'h0) begin
                    wait (i_line);
                    if ($realtime - t0 >= 12 * o_bit * CLK_NS) begin
                        {synced, stuck, clk_sel} = 4'b0011;
                        o_breaks++;
                    end
                end else if (!stuck) begin
                    o_rx = {f[0] | ~f[10] | ~f[11] | ^f[9:1], f[8:1]};
                    stuck = o_rx[8];
                    o_stb = 1;
                    #1 o_stb = 0;
                    // guard bits, drive only the reply
                    if (!stuck) begin
                        bits(GUARD + 0.5);
                        f = {2'b11, ^f[8:1] ^ i_bad_par, ~f[8:1], 1'b0};
                        o_oe_n <= 0;
                        for (int i = 0; i < 12; i++) begin
                            o_out <= f[i];
                            bits(1);
                        end
                        {o_out, o_oe_n} <= 2'b11;
                    end
                end
            end
        end
    end
endmodule // owdh_dev_model

// file: owdh_host_tb.sv
module owdh_host_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk, srst, awv, wv, bready, arv, rready, badp, parity_check_disable;
    logic        awr, wr, bv, arr, rv, hout, hoe_n, dout, doe_n, stb;
    logic [3:0]  awaddr, araddr;
    logic [31:0] wdata, rd, rdata, seed;
    logic [15:0] div;
    logic [1:0]  bresp, rresp;
    logic [8:0]  rx;
    wire         line;
    int          bitlen, breaks;
    int          fail_count = 0;
    int          checked = 0;
    logic [67:0] rq[$];
    logic [8:0]  dq[$];
    logic [67:0] e;

    // Pull-up wire: a released party reads as high
    assign line = (hoe_n | hout) & (doe_n | dout);

    initial begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end

    owdh_host #(.BREAK_CYC(200)) dut (
        .i_ref_clk(clk), .i_srst(srst), .i_awaddr(awaddr),
        .i_awvalid(awv), .o_awready(awr), .i_wdata(wdata),
        .i_wstrb(4'hf), .i_wvalid(wv), .o_wready(wr), .o_bresp(bresp),
        .o_bvalid(bv), .i_bready(bready), .i_araddr(araddr),
        .i_arvalid(arv), .o_arready(arr), .o_rdata(rdata),
        .o_rresp(rresp), .o_rvalid(rv), .i_rready(rready),
        .i_wire_in(line), .o_wire_out(hout), .o_wire_oe_n(hoe_n));

    owdh_dev_model u_dev (
        .i_clk(clk), .i_line(line), .i_bad_par(badp), .o_out(dout),
        .o_oe_n(doe_n), .o_stb(stb), .o_rx(rx), .o_bit(bitlen),
        .o_breaks(breaks));

    task automatic chk(input logic [33:0] s, input logic [33:0] x);
        checked++;
        if (s !== x) begin
            fail_count++;
            $display("[ERR] %0t seen %h exp %h", $time, s, x);
        end
    endtask

    task automatic final_report;
        if (fail_count == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Answer watcher: oldest note against each bus answer
    always @(posedge clk)
        if ((bv && bready) || (rv && rready)) begin
            e = rq.pop_front();
            if (e[67])
                chk(e[66] ? {rresp, rdata & e[31:0]} : {bresp, 32'h0},
                    e[65:32]);
        end

    // Byte watcher on the device side
    always @(posedge stb)
        chk({25'h0, rx}, {25'h0, dq.pop_front()});

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    task automatic wr32(input logic [3:0] a, input logic [31:0] d,
                        input logic [1:0] r);
        rq.push_back({2'b10, r, 64'h0});
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        {awv, wv, bready} <= 3'b111;
        fork
            begin
                do @(posedge clk); while (!awr);
                awv <= 0;
            end
            begin
                do @(posedge clk); while (!wr);
                wv <= 0;
            end
        join
        do @(posedge clk); while (!bv);
        bready <= 0;
    endtask

    // Read with a note: check flag, expected resp/data, data mask
    task automatic rd32(input logic [3:0] a, input logic c,
                        input logic [33:0] x, input logic [31:0] m);
        rq.push_back({c, 1'b1, x, m});
        @(posedge clk);
        araddr <= a;
        {arv, rready} <= 2'b11;
        do @(posedge clk); while (!arr);
        arv <= 0;
        do @(posedge clk); while (!rv);
        rd = rdata;
        rready <= 0;
    endtask

    // Status poll; the watchdog bounds a hang
    task automatic poll(input int b, input logic v);
        do rd32(4'h4, 1'b0, 34'h0, 32'h0); while (rd[b] !== v);
    endtask

    task automatic ctl(input logic [2:0] c);
        wr32(4'h0, {div, 11'h0, parity_check_disable, 1'b0, c}, 2'h0);
    endtask

    task automatic send(input logic [7:0] b);
        wr32(4'h8, {24'h0, b}, 2'h0);
        ctl(3'h1);
        poll(0, 1'b0);
    endtask

    // Byte out, inverted reply back, then status after the pop
    task automatic xfer(input logic [7:0] b, input logic bp);
        badp <= bp;
        dq.push_back({1'b0, b});
        send(b);
        ctl(3'h2);
        poll(6, 1'b1);
        rd32(4'hc, 1'b1, {25'h0, bp & !parity_check_disable, ~b}, 32'h1ff);
        rd32(4'h4, 1'b1, {28'h0, 1'b1, bp & !parity_check_disable, 4'h0}, 32'h70);
    endtask

    initial begin
        {srst, awv, wv, bready, arv, rready, badp, parity_check_disable} = 8'h80;
        {awaddr, araddr, wdata} = 40'h0;
        seed = 32'd51804;
        div = 16'd16;
        repeat (5) @(posedge clk);
        srst <= 0;
        // Reset values and unmapped offsets
        rd32(4'h0, 1'b1, {2'h0, 32'h00b2_0000}, 32'hffff_0000);
        rd32(4'h4, 1'b1, 34'h0, 32'h0000_00f1);
        rd32(4'h2, 1'b1, {2'h2, 32'h0}, 32'hffff_ffff);
        wr32(4'h6, 32'h0, 2'h2);
        // enable pulse, then wait for the device to let go
        ctl(3'h4);
        poll(0, 1'b0);
        for (int k = 0; k < 400 && !line; k++) @(posedge clk);
        send(8'h55);
        chk(34'(bitlen), 34'(div));
        // Random bytes, parity faults with the check on and off
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            parity_check_disable = (i > 3);
            xfer(seed[7:0], i[0]);
        end
        // Two breaks, then resync at a new rate
        ctl(3'h3);
        poll(0, 1'b0);
        chk(34'(breaks), 34'h1);
        ctl(3'h3);
        poll(0, 1'b0);
        chk(34'(breaks), 34'h2);
        div = 16'd20;
        send(8'h55);
        chk(34'(bitlen), 34'(div));
        xfer(8'ha6, 1'b0);
        final_report;
    end

    // Watchdog well beyond the few thousand cycles the run needs
    initial begin
        repeat (50000) @(posedge clk);
        fail_count++;
        final_report;
    end
endmodule // owdh_host_tb

bind owdh_host owdh_host_chk u_chk (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_awvalid(i_awvalid),
    .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready),
    .o_bvalid(o_bvalid), .o_bresp(o_bresp), .i_bready(i_bready),
    .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
    .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
    .i_rready(i_rready), .o_wire_out(o_wire_out),
    .o_wire_oe_n(o_wire_oe_n));
